/* verilog/lane_mapper_regs.vh */
// register map, field positions, reset values and mode codes of the lane mapper
// assumes a 32-bit AHB-Lite register bus with one register per aligned word
`ifndef LANE_MAPPER_REGS_VH
`define LANE_MAPPER_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 6'h00
`define OFS_DEVCFG 6'h04
`define OFS_DEVID 6'h08
`define OFS_KFRAMES 6'h0C
`define OFS_STATUS 6'h10
`define OFS_LANE_PWR 6'h14

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 4
`define CTRL_SHUT_A 8
`define CTRL_SHUT_B 9
`define CTRL_KEEP_A 10
`define CTRL_KEEP_B 11
`define CTRL_LINK_EN 12

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define ST_MODE_OK 0
`define ST_DES 1
`define ST_LANES_LSB 4
`define ST_LANES_MSB 7
`define ST_RATE_LSB 8
`define ST_RATE_MSB 12
`define ST_K_OK 13
`define ST_ALL_OFF 14
`define ST_PIN_DOWN 15

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_MODE 5'h04
`define RST_DEVCFG 8'h00
`define RST_DEVID 8'h00
`define RST_KFRAMES 6'h20

// ------------------------------------------------------------
// link modes and frame length limits
// ------------------------------------------------------------
`define MODE_S2 5'h04
`define MODE_S4 5'h05
`define MODE_D2 5'h06
`define MODE_D4 5'h07
`define MODE_S8 5'h11
`define MODE_D8 5'h12
`define K_MIN 6'h12
`define K_MAX 6'h20
`define DEVCFG_RUN0 8'h00
`define DEVCFG_RUN1 8'h01

// line rate per lane, in quarter bits per device clock
`define RATE_X4_L2 5'h14
`define RATE_X4_L4 5'h0A
`define RATE_X4_L8 5'h05

// idle toggling octet for spare lanes kept alive
`define KEEPALIVE_OCTET 8'h55

`endif

/* verilog/link_mode_decode.v */
// decodes the link mode selector into the derived link parameters
// assumes a settled selector; purely combinational
`timescale 1ns/1ps
`default_nettype none

module link_mode_decode
(
    input wire [4:0] link_mode_select,
    output reg mode_ok,
    output reg des,
    output reg [3:0] lanes,
    output reg [4:0] rate_x4
);

`include "lane_mapper_regs.vh"

// ------------------------------------------------------------
// mode table; one octet per frame, 8-bit samples in all modes
// ------------------------------------------------------------
always @*
begin
    mode_ok = 1'b1;
    des = 1'b0;
    lanes = 4'h0;
    rate_x4 = 5'h00;
    case (link_mode_select)
        `MODE_S2:
        begin
            des = 1'b1;
            lanes = 4'h2;
            rate_x4 = `RATE_X4_L2;
        end
        `MODE_S4:
        begin
            des = 1'b1;
            lanes = 4'h4;
            rate_x4 = `RATE_X4_L4;
        end
        `MODE_D2:
        begin
            lanes = 4'h2;
            rate_x4 = `RATE_X4_L2;
        end
        `MODE_D4:
        begin
            lanes = 4'h4;
            rate_x4 = `RATE_X4_L4;
        end
        `MODE_S8:
        begin
            des = 1'b1;
            lanes = 4'h8;
            rate_x4 = `RATE_X4_L8;
        end
        `MODE_D8:
        begin
            lanes = 4'h8;
            rate_x4 = `RATE_X4_L8;
        end
        default:
            mode_ok = 1'b0;
    endcase
end

endmodule

`default_nettype wire

/* verilog/jesd_transport_lane_mapper.v */
// transport-layer sample to lane mapper with lane power control
// assumes one frame of samples per device clock and an AHB-Lite master
// on the same clock; the serializer and link layer sit downstream
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module jesd_transport_lane_mapper
(
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output reg [31:0] hrdata,
    output wire hresp,
    input wire shutdown_pin,
    input wire [127:0] sample_data,
    input wire sample_valid,
    output reg [63:0] link_a_lane,
    output reg [63:0] link_b_lane,
    output reg [7:0] link_a_lane_pwr,
    output reg [7:0] link_b_lane_pwr,
    output reg frame_valid,
    output reg [7:0] link_a_devid,
    output reg [7:0] link_b_devid,
    output wire [23:0] link_a_lane_id,
    output wire [23:0] link_b_lane_id,
    output reg [4:0] lane_rate_x4,
    output reg link_enable,
    output reg relink_req
);

`include "lane_mapper_regs.vh"

parameter LANES_PER_LINK = 8;

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
function [7:0] octet_at;
    input [127:0] frame;
    input integer idx;
    begin
        octet_at = frame[idx * 8 +: 8];
    end
endfunction

function [7:0] lane_mask;
    input [3:0] used;
    integer n;
    begin
        lane_mask = 8'h00;
        for (n = 0; n < 8; n = n + 1)
            if (n < used)
                lane_mask[n] = 1'b1;
    end
endfunction

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [4:0] link_mode_select;
reg chan_a_shutdown;
reg chan_b_shutdown;
reg spare_lane_keepalive_a;
reg spare_lane_keepalive_b;
reg [7:0] devcfg_mode;
reg [7:0] devid;
reg [5:0] kframes;

// ------------------------------------------------------------
// derived link parameters
// ------------------------------------------------------------
wire mode_ok;
wire des;
wire [3:0] lanes;
wire [4:0] rate_x4;

link_mode_decode u_decode
(
    .link_mode_select(link_mode_select),
    .mode_ok(mode_ok),
    .des(des),
    .lanes(lanes),
    .rate_x4(rate_x4)
);

// frame length must sit in range and be even
wire k_ok = (kframes >= `K_MIN) && (kframes <= `K_MAX) && !kframes[0];

// ------------------------------------------------------------
// shutdown pin synchroniser
// ------------------------------------------------------------
reg pin_s1;
reg pin_s2;
reg pin_s3;
reg pin_down;

always @(posedge clk)
begin
    if (rst)
    begin
        pin_s1 <= 1'b0;
        pin_s2 <= 1'b0;
        pin_s3 <= 1'b0;
        pin_down <= 1'b0;
    end
    else
    begin
        pin_s1 <= shutdown_pin;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        if (pin_s2 == pin_s3)
            pin_down <= pin_s3;
    end
end

// ------------------------------------------------------------
// power decisions
// ------------------------------------------------------------
// unlisted modes have no defined lanes, so nothing is driven
wire mode_off = !mode_ok;
wire cfg_off = (devcfg_mode != `DEVCFG_RUN0) && (devcfg_mode != `DEVCFG_RUN1);
wire all_off = pin_down || cfg_off || mode_off;
// in single-channel mode both links carry channel A
wire link_a_shut = chan_a_shutdown;
wire link_b_shut = des ? chan_a_shutdown : chan_b_shutdown;
wire [7:0] used_mask = lane_mask(lanes);

reg [7:0] next_pwr_a;
reg [7:0] next_pwr_b;

always @*
begin
    next_pwr_a = 8'h00;
    next_pwr_b = 8'h00;
    if (!all_off)
    begin
        if (!link_a_shut)
            next_pwr_a = used_mask | {8{spare_lane_keepalive_a}};
        if (!link_b_shut)
            next_pwr_b = used_mask | {8{spare_lane_keepalive_b}};
    end
end

// ------------------------------------------------------------
// sample to lane mapping
// ------------------------------------------------------------
// octet bit 7 is the sample MSB and goes out first; with eight
// bit samples and one octet per frame there are no tail bits
reg [63:0] next_lane_a;
reg [63:0] next_lane_b;
integer i;

always @*
begin
    next_lane_a = 64'h0;
    next_lane_b = 64'h0;
    for (i = 0; i < LANES_PER_LINK; i = i + 1)
    begin
        if (used_mask[i])
        begin
            if (des)
            begin
                next_lane_a[i * 8 +: 8] = octet_at(sample_data, 2 * i);
                next_lane_b[i * 8 +: 8] = octet_at(sample_data, 2 * i + 1);
            end
            else
            begin
                next_lane_a[i * 8 +: 8] = octet_at(sample_data, i);
                next_lane_b[i * 8 +: 8] = octet_at(sample_data, 8 + i);
            end
        end
        else
        begin
            if (spare_lane_keepalive_a)
                next_lane_a[i * 8 +: 8] = `KEEPALIVE_OCTET;
            if (spare_lane_keepalive_b)
                next_lane_b[i * 8 +: 8] = `KEEPALIVE_OCTET;
        end
        if (!next_pwr_a[i])
            next_lane_a[i * 8 +: 8] = 8'h00;
        if (!next_pwr_b[i])
            next_lane_b[i * 8 +: 8] = 8'h00;
    end
end

// spare lanes flip their idle octet every clock to keep toggling
reg keep_phase;

always @(posedge clk)
begin
    if (rst)
    begin
        link_a_lane <= 64'h0;
        link_b_lane <= 64'h0;
        link_a_lane_pwr <= 8'h00;
        link_b_lane_pwr <= 8'h00;
        frame_valid <= 1'b0;
        keep_phase <= 1'b0;
    end
    else
    begin
        keep_phase <= !keep_phase;
        link_a_lane <= keep_phase ? (next_lane_a ^ keep_mask(used_mask, next_pwr_a))
            : next_lane_a;
        link_b_lane <= keep_phase ? (next_lane_b ^ keep_mask(used_mask, next_pwr_b))
            : next_lane_b;
        link_a_lane_pwr <= next_pwr_a;
        link_b_lane_pwr <= next_pwr_b;
        frame_valid <= sample_valid && !all_off;
    end
end

// inverts the octets of spare lanes that are powered
function [63:0] keep_mask;
    input [7:0] used;
    input [7:0] pwr;
    integer n;
    begin
        keep_mask = 64'h0;
        for (n = 0; n < 8; n = n + 1)
            if (!used[n] && pwr[n])
                keep_mask[n * 8 +: 8] = 8'hFF;
    end
endfunction

// ------------------------------------------------------------
// identifiers and rate
// ------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < LANES_PER_LINK; g = g + 1)
    begin : g_lid
        localparam [2:0] LID = g;
        assign link_a_lane_id[g * 3 +: 3] = LID;
        assign link_b_lane_id[g * 3 +: 3] = LID;
    end
endgenerate

// leaving power-down asks the link layer to resynchronise
reg was_off;

always @(posedge clk)
begin
    if (rst)
    begin
        link_a_devid <= `RST_DEVID;
        link_b_devid <= `RST_DEVID + 8'h01;
        lane_rate_x4 <= 5'h00;
        was_off <= 1'b1;
        relink_req <= 1'b0;
    end
    else
    begin
        link_a_devid <= devid;
        link_b_devid <= devid + 8'h01;
        lane_rate_x4 <= rate_x4;
        was_off <= all_off;
        relink_req <= was_off && !all_off;
    end
end

// ------------------------------------------------------------
// AHB-Lite slave: zero wait states, always OKAY
// ------------------------------------------------------------
assign hreadyout = 1'b1;
assign hresp = 1'b0;

reg wr_pend;
reg [5:0] wr_addr;
wire take = hsel && hready && htrans[1];

wire [31:0] status_word = {16'h0, pin_down, all_off, k_ok, rate_x4, lanes,
    2'b00, des, mode_ok};

reg [31:0] rd_word;

always @*
begin
    case (haddr[5:0])
        `OFS_CTRL:
            rd_word = {19'h0, link_enable, spare_lane_keepalive_b,
                spare_lane_keepalive_a, chan_b_shutdown, chan_a_shutdown,
                3'h0, link_mode_select};
        `OFS_DEVCFG:
            rd_word = {24'h0, devcfg_mode};
        `OFS_DEVID:
            rd_word = {24'h0, devid};
        `OFS_KFRAMES:
            rd_word = {26'h0, kframes};
        `OFS_STATUS:
            rd_word = status_word;
        `OFS_LANE_PWR:
            rd_word = {16'h0, link_b_lane_pwr, link_a_lane_pwr};
        default:
            rd_word = 32'h0;
    endcase
end

// settings are meant to change only with the link disabled
// the block applies them at once regardless
always @(posedge clk)
begin
    if (rst)
    begin
        wr_pend <= 1'b0;
        wr_addr <= 6'h00;
        hrdata <= 32'h0;
        link_mode_select <= `RST_MODE;
        chan_a_shutdown <= 1'b0;
        chan_b_shutdown <= 1'b0;
        spare_lane_keepalive_a <= 1'b0;
        spare_lane_keepalive_b <= 1'b0;
        link_enable <= 1'b0;
        devcfg_mode <= `RST_DEVCFG;
        devid <= `RST_DEVID;
        kframes <= `RST_KFRAMES;
    end
    else
    begin
        wr_pend <= take && hwrite && (haddr[31:6] == 26'h0);
        wr_addr <= haddr[5:0];
        if (take && !hwrite)
            hrdata <= (haddr[31:6] == 26'h0) ? rd_word : 32'h0;
        if (wr_pend)
        begin
            case (wr_addr)
                `OFS_CTRL:
                begin
                    link_mode_select <= hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
                    chan_a_shutdown <= hwdata[`CTRL_SHUT_A];
                    chan_b_shutdown <= hwdata[`CTRL_SHUT_B];
                    spare_lane_keepalive_a <= hwdata[`CTRL_KEEP_A];
                    spare_lane_keepalive_b <= hwdata[`CTRL_KEEP_B];
                    link_enable <= hwdata[`CTRL_LINK_EN];
                end
                `OFS_DEVCFG:
                    devcfg_mode <= hwdata[7:0];
                `OFS_DEVID:
                    devid <= hwdata[7:0];
                `OFS_KFRAMES:
                    kframes <= hwdata[5:0];
                default:
                    ;
            endcase
        end
    end
end

endmodule

`default_nettype wire

/* verilog/lane_mapper_regs_dummy_guard.v */
`timescale 1ns/1ps

/* test/lane_receiver.sv */
// receiver-side model: keeps the last mapped frame seen on both links
// assumes the mapper's lane outputs, frame strobe and relink pulse on one clock
`timescale 1ns/1ps
`default_nettype none
module lane_receiver
#(
    parameter int FLUSH = 4
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic frame_valid,
    input wire logic relink_req,
    input wire logic [63:0] link_a_lane,
    input wire logic [63:0] link_b_lane,
    output logic [63:0] got_a,
    output logic [63:0] got_b
);
    int hold;
    // ----------------------------------------
    // capture, dropping frames while the pipeline flushes
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rst || relink_req)
            hold <= FLUSH;
        else if (hold != 0)
            hold <= hold - 1;
        else if (frame_valid)
        begin
            got_a <= link_a_lane;
            got_b <= link_b_lane;
        end
    end
endmodule
`default_nettype wire

/* test/lane_mapper_sva.sv */
// port assertions of the lane mapper
// assumes the mapper's top-level ports; bound after the module
`timescale 1ns/1ps
`default_nettype none
module lane_mapper_sva
#(
    parameter LANES_PER_LINK = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic shutdown_pin,
    input wire logic [127:0] sample_data,
    input wire logic [63:0] link_a_lane,
    input wire logic [63:0] link_b_lane,
    input wire logic [7:0] link_a_lane_pwr,
    input wire logic [7:0] link_b_lane_pwr,
    input wire logic [7:0] link_a_devid,
    input wire logic [7:0] link_b_devid,
    input wire logic [23:0] link_a_lane_id,
    input wire logic [23:0] link_b_lane_id,
    input wire logic [4:0] lane_rate_x4,
    input wire logic relink_req
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [63:0] mask_a;
    logic [63:0] mask_b;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            mask_a[8*i +: 8] = {8{link_a_lane_pwr[i]}};
            mask_b[8*i +: 8] = {8{link_b_lane_pwr[i]}};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence pin_held;
        shutdown_pin [*6];
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    lane_ids_a: assert property (link_a_lane_id == 24'hFAC688 && link_b_lane_id == 24'hFAC688)
        else $error("lane identifiers wrong");
    devid_step_a: assert property (link_b_devid == link_a_devid + 8'h01)
        else $error("link b identifier not a plus one");
    pin_down_a: assert property (pin_held |-> {link_a_lane_pwr, link_b_lane_pwr} == 16'h0)
        else $error("lanes powered with pin down");
    dark_lanes_a: assert property (((link_a_lane & ~mask_a) | (link_b_lane & ~mask_b)) == 64'h0)
        else $error("unpowered lane carries data");
    lane0_map_a: assert property (link_a_lane_pwr[0] && $past(link_a_lane_pwr[0])
        |-> link_a_lane[7:0] == $past(sample_data[7:0])) else $error("lane 0 octet wrong");
    relink_pulse_a: assert property (relink_req |=> !relink_req)
        else $error("relink longer than one cycle");
    keepalive_a: assert property (link_a_lane_pwr[7] && $past(link_a_lane_pwr[7])
        && lane_rate_x4 != 5'h05 |-> link_a_lane[63:56] inside {8'h55, 8'hAA}
        && link_a_lane[63:56] != $past(link_a_lane[63:56])) else $error("spare lane not toggling");
    rate_code_a: assert property (lane_rate_x4 inside {5'h00, 5'h05, 5'h0A, 5'h14})
        else $error("rate code out of set");
endmodule
bind jesd_transport_lane_mapper lane_mapper_sva #(.LANES_PER_LINK(LANES_PER_LINK)) sva (
    .clk(clk), .rst(rst), .shutdown_pin(shutdown_pin), .sample_data(sample_data),
    .link_a_lane(link_a_lane), .link_b_lane(link_b_lane), .link_a_lane_pwr(link_a_lane_pwr),
    .link_b_lane_pwr(link_b_lane_pwr), .link_a_devid(link_a_devid), .link_b_devid(link_b_devid),
    .link_a_lane_id(link_a_lane_id), .link_b_lane_id(link_b_lane_id),
    .lane_rate_x4(lane_rate_x4), .relink_req(relink_req));
`default_nettype wire

/* test/jesd_transport_lane_mapper_bench.sv */
// self-checking bench: bus tasks, mode table, power controls of the lane mapper
// assumes the mapper, its register header, the receiver model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "lane_mapper_regs.vh"
module jesd_transport_lane_mapper_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 0;
    logic rst = 1;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [31:0] hwdata = 0;
    logic shutdown_pin = 0;
    logic [127:0] sample_data;
    logic hready, hresp, fv, len, rl;
    logic [31:0] hrdata;
    logic [63:0] la, lb, got_a, got_b;
    logic [7:0] pa, pb, da, db;
    logic [23:0] ida, idb;
    logic [4:0] rate;
    int mismatches = 0;
    int num_checks = 0;
    int mode_tab[6] = '{4, 5, 6, 7, 17, 18};
    int l_tab[6] = '{2, 4, 2, 4, 8, 8};
    int d_tab[6] = '{1, 1, 0, 0, 1, 0};
    int r_tab[6] = '{20, 10, 20, 10, 5, 5};
    jesd_transport_lane_mapper dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .shutdown_pin(shutdown_pin),
        .sample_data(sample_data), .sample_valid(1'b1), .link_a_lane(la), .link_b_lane(lb),
        .link_a_lane_pwr(pa), .link_b_lane_pwr(pb), .frame_valid(fv), .link_a_devid(da),
        .link_b_devid(db), .link_a_lane_id(ida), .link_b_lane_id(idb), .lane_rate_x4(rate),
        .link_enable(len), .relink_req(rl));
    lane_receiver rx (.clk(clk), .rst(rst), .frame_valid(fv), .relink_req(rl),
        .link_a_lane(la), .link_b_lane(lb), .got_a(got_a), .got_b(got_b));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [7:0] oct(input logic [3:0] n);
        return {n, ~n};
    endfunction
    function automatic logic [63:0] exp_lane(input int k, input int b);
        logic [63:0] v = 64'h0;
        for (int i = 0; i < l_tab[k]; i++)
            v[8*i +: 8] = d_tab[k] ? oct(2*i + b) : oct(8*b + i);
        return v;
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {26'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check(what, hrdata, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (8) @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        for (int n = 0; n < 16; n++)
            sample_data[8*n +: 8] <= oct(n);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`OFS_CTRL, 32'h4, "ctrl reset");
        rd(`OFS_DEVCFG, 32'h0, "devcfg reset");
        rd(`OFS_KFRAMES, 32'h20, "k reset");
        rd(`OFS_STATUS, 32'h3423, "status reset");
        rd(6'h18, 32'h0, "unmapped");
        wr(`OFS_KFRAMES, 32'h13);
        rd(`OFS_STATUS, 32'h1423, "odd k");
        wr(`OFS_KFRAMES, 32'h12);
        rd(`OFS_STATUS, 32'h3423, "k min");
        rd(`OFS_KFRAMES, 32'h12, "k readback");
        check("lane ids", {ida, idb}, 48'hFAC688FAC688);
        for (int k = 0; k < 6; k++)
        begin
            wr(`OFS_CTRL, mode_tab[k]);
            rd(`OFS_STATUS, 32'h2001 | d_tab[k] << 1 | l_tab[k] << 4 | r_tab[k] << 8, "status");
            check("rate", rate, r_tab[k]);
            check("pwr", {pa, pb}, ((9'h1 << l_tab[k]) - 9'h1) * 16'h0101);
            check("lanes a", got_a, exp_lane(k, 0));
            check("lanes b", got_b, exp_lane(k, 1));
        end
        wr(`OFS_CTRL, 32'h8);
        check("unlisted", {pa, pb, rate, fv, hresp}, 0);
        wr(`OFS_DEVID, 32'hFF);
        check("devid", {da, db}, 16'hFF00);
        wr(`OFS_DEVID, 32'h3C);
        check("devid", {da, db}, 16'h3C3D);
        wr(`OFS_CTRL, 32'h404);
        check("keep a", {pa, pb}, 16'hFF03);
        wr(`OFS_CTRL, 32'h1C04);
        check("keep both", {len, pa, pb}, 17'h1FFFF);
        wr(`OFS_CTRL, 32'h212);
        check("shut b dual", {pa, pb}, 16'hFF00);
        wr(`OFS_CTRL, 32'h111);
        check("shut a single", {pa, pb}, 16'h0);
        wr(`OFS_CTRL, 32'h12);
        wr(`OFS_DEVCFG, 32'h2);
        check("devcfg off", {pa, pb, fv}, 0);
        wr(`OFS_DEVCFG, 32'h1);
        check("devcfg run", {pa, pb}, 16'hFFFF);
        shutdown_pin <= 1'b1;
        repeat (8) @(posedge clk);
        check("pin off", {pa, pb, fv}, 0);
        shutdown_pin <= 1'b0;
        for (int n = 0; n < 20 && rl !== 1'b1; n++)
            @(negedge clk);
        check("relink", rl, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
